// [rtl/keypad_cfg_pkg.sv]
// constants shared by the keypad configuration and supervision logic
// assumes a 10 MHz system clock and static switch straps
// Functional notes
// RL1 - the unit address is the four weighted switches 8,4,2,1, and all-off means address 16.
// RL2 - the panel maps addresses 1 to 8 to door entries and 9 to 16 to door exits.
// RL3 - the panel handles at most sixteen keypad addresses on one link.
// RL4 - the panel reads a keypad's address before doing anything involving it.
// RL5 - a duplicate address seen on the link flashes the red front indicator.
// RL6 - on the older variant the timeout switch picks 15 s when on and 10 s when off.
// RL7 - no keystroke within the timeout discards the entry and returns to the reset state.
// RL8 - an enabled tamper flashes all indicators red and disables the unit, and the panel alarms.
// RL9 - key test shows each key in binary on the bottom indicators, hash 10, star 11, start 12.
// RL10 - display test lights each digit in turn with all segments on, showing 8.
// RL11 - on the newer variant the dual-reader switch enables the second reader port.
// RL12 - the format switch picks mag stripe when off and Wiegand when on, for both ports.
// RL13 - the style switch picks swipe when off and insert when on, for both ports.
// RL14 - on the newer variant the tamper-enable switch on enables tamper detection.
// RL15 - on the newer variant tests run only with test-enable on; test-select off is display, on is key.
// RL16 - switch inputs are debounced after reset and the decoded settings are held stable.
package keypad_cfg_pkg;
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned TIMEOUT_LONG_S = 15;
    localparam int unsigned TIMEOUT_SHORT_S = 10;
    localparam int unsigned TIMEOUT_LONG_CYC = TIMEOUT_LONG_S * CLK_HZ;
    localparam int unsigned TIMEOUT_SHORT_CYC = TIMEOUT_SHORT_S * CLK_HZ;
    localparam int unsigned DEBOUNCE_MS = 20;
    localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_MS * (CLK_HZ / 1000);
    localparam int unsigned FLASH_MS = 250;
    localparam int unsigned FLASH_CYC = FLASH_MS * (CLK_HZ / 1000);
    localparam int unsigned STEP_MS = 500;
    localparam int unsigned STEP_CYC = STEP_MS * (CLK_HZ / 1000);
    localparam logic [4:0] ADDR_ALL_OFF = 5'h10;
    localparam logic [3:0] KEY_HASH = 4'ha;
    localparam logic [3:0] KEY_STAR = 4'hb;
    localparam logic [3:0] KEY_START = 4'hc;
    localparam logic [6:0] SEG_EIGHT = 7'h7f;
    localparam int unsigned SW_COUNT = 10;
    // switch bit positions, 0 = weight-8 address switch
    localparam int unsigned SW_TIMEOUT_DUAL = 4;
    localparam int unsigned SW_TAMPER_FMT = 5;
    localparam int unsigned SW_KEYTEST_STYLE = 6;
    localparam int unsigned SW_DISP_TAMPER = 7;
    localparam int unsigned SW_TEST_SEL = 8;
    localparam int unsigned SW_TEST_EN = 9;
    localparam logic [SW_COUNT-1:0] SW_RESET = 10'h000;
    typedef enum logic [1:0] {MODE_RUN, MODE_KEYTEST, MODE_DISPTEST, MODE_TAMPER} mode_t;
endpackage : keypad_cfg_pkg

// [rtl/switch_debounce.sv]
// debouncer for a bank of static configuration switches
// assumes inputs synchronous to the clock and a synchronised reset
`timescale 1ns/1ns
`default_nettype none
module switch_debounce
    import keypad_cfg_pkg::*;
#(
    parameter int unsigned WIDTH = SW_COUNT,
    parameter int unsigned STABLE_CYC = DEBOUNCE_CYC
)
(
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic [WIDTH-1:0] i_raw,
    output logic [WIDTH-1:0] o_clean,
    output logic o_valid
);
    // refuse parameter values the counter cannot serve
    if (STABLE_CYC < 1 || WIDTH < 1)
    begin : g_bad_param
        $error("switch_debounce: bad parameters");
    end

    logic [WIDTH-1:0] last_r;
    logic [31:0] cnt_r;

    // --------------------------------------------------------------
    // settle counter: accept once inputs hold still long enough
    // --------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            last_r <= '0;
            cnt_r <= '0;
            o_clean <= '0;
            o_valid <= 1'b0;
        end
        else
        begin
            last_r <= i_raw;
            if (i_raw != last_r)
                cnt_r <= '0;
            else if (cnt_r < STABLE_CYC)
                cnt_r <= cnt_r + 32'h1;
            else
            begin
                o_clean <= i_raw; // [RL16]
                o_valid <= 1'b1;
            end
        end
    end
endmodule : switch_debounce
`default_nettype wire

// [rtl/keypad_config.sv]
// keypad reader configuration decode, entry timeout, tamper and test modes
// assumes switch, key and link-status inputs synchronous to i_clk_sys
`timescale 1ns/1ns
`default_nettype none
module keypad_config
    import keypad_cfg_pkg::*;
#(
    parameter int unsigned TO_LONG_CYC = TIMEOUT_LONG_CYC,
    parameter int unsigned TO_SHORT_CYC = TIMEOUT_SHORT_CYC,
    parameter int unsigned DEB_CYC = DEBOUNCE_CYC,
    parameter int unsigned FLASH_HALF_CYC = FLASH_CYC,
    parameter int unsigned STEP_LEN_CYC = STEP_CYC,
    parameter int unsigned DIGITS = 4
)
(
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_newer_variant,
    input wire logic i_addr_weight8_switch,
    input wire logic i_addr_weight4_switch,
    input wire logic i_addr_weight2_switch,
    input wire logic i_addr_weight1_switch,
    input wire logic i_timeout_or_dual_reader_switch,
    input wire logic i_tamper_or_format_switch,
    input wire logic i_keytest_or_style_switch,
    input wire logic i_display_test_or_tamper_switch,
    input wire logic i_test_select_switch,
    input wire logic i_test_enable_switch,
    input wire logic i_key_strobe,
    input wire logic [3:0] i_key_code,
    input wire logic i_entry_active,
    input wire logic i_dup_addr_seen,
    input wire logic i_tamper_sense,
    output logic [4:0] o_unit_address,
    output logic o_cfg_valid,
    output logic o_entry_abort,
    output logic o_reader2_enable,
    output logic o_fmt_wiegand,
    output logic o_style_insert,
    output logic o_tamper_alarm,
    output logic o_device_disabled,
    output logic o_red_front,
    output logic o_all_red,
    output logic [3:0] o_bottom_leds,
    output logic [DIGITS-1:0] o_digit_sel,
    output logic [6:0] o_segments
);
    // refuse parameter values the counters and digit index cannot serve
    if (TO_LONG_CYC < 2 || TO_SHORT_CYC < 2 || DIGITS < 1 || DIGITS > 16 ||
        FLASH_HALF_CYC < 1 || STEP_LEN_CYC < 1)
    begin : g_bad_param
        $error("keypad_config: unsupported parameter values");
    end

    // --------------------------------------------------------------
    // reset release through two flops
    // --------------------------------------------------------------
    logic rst_s1_r;
    logic rst_n;
    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            rst_s1_r <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_s1_r <= 1'b1;
            rst_n <= rst_s1_r;
        end
    end

    // --------------------------------------------------------------
    // switch debounce and hold
    // --------------------------------------------------------------
    logic [SW_COUNT-1:0] sw;
    logic cfg_ok;
    switch_debounce #(.WIDTH(SW_COUNT), .STABLE_CYC(DEB_CYC)) u_deb (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(rst_n),
        .i_raw({i_test_enable_switch, i_test_select_switch,
                i_display_test_or_tamper_switch, i_keytest_or_style_switch,
                i_tamper_or_format_switch, i_timeout_or_dual_reader_switch,
                i_addr_weight1_switch, i_addr_weight2_switch,
                i_addr_weight4_switch, i_addr_weight8_switch}),
        .o_clean(sw),
        .o_valid(cfg_ok)
    );

    // weights 8,4,2,1; all off reads as 16
    function automatic logic [4:0] decode_addr(input logic [3:0] bits);
        decode_addr = (bits == 4'h0) ? ADDR_ALL_OFF : {1'b0, bits};
    endfunction : decode_addr

    // decoded mode from the switches, per variant
    logic tamper_en;
    logic keytest_req;
    logic disptest_req;
    assign tamper_en = i_newer_variant ? sw[SW_DISP_TAMPER] : sw[SW_TAMPER_FMT]; // [RL14]
    assign keytest_req = i_newer_variant ? (sw[SW_TEST_EN] & sw[SW_TEST_SEL])
                                         : sw[SW_KEYTEST_STYLE]; // [RL15]
    assign disptest_req = i_newer_variant ? (sw[SW_TEST_EN] & ~sw[SW_TEST_SEL])
                                          : sw[SW_DISP_TAMPER]; // [RL15]

    // --------------------------------------------------------------
    // registered configuration outputs
    // --------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            o_unit_address <= ADDR_ALL_OFF;
            o_cfg_valid <= 1'b0;
            o_reader2_enable <= 1'b0;
            o_fmt_wiegand <= 1'b0;
            o_style_insert <= 1'b0;
        end
        else
        begin
            o_cfg_valid <= cfg_ok;
            // sw[0] is the weight-8 switch, so the bits are reversed into place
            o_unit_address <= decode_addr({sw[0], sw[1], sw[2], sw[3]}); // [RL1]
            o_reader2_enable <= i_newer_variant & sw[SW_TIMEOUT_DUAL]; // [RL11]
            o_fmt_wiegand <= i_newer_variant & sw[SW_TAMPER_FMT]; // [RL12]
            o_style_insert <= i_newer_variant & sw[SW_KEYTEST_STYLE]; // [RL13]
        end
    end

    // --------------------------------------------------------------
    // mode machine: tamper latches and dominates
    // --------------------------------------------------------------
    mode_t mode_r;
    always_ff @(posedge i_clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            mode_r <= MODE_RUN;
        else
        begin
            case (mode_r)
                MODE_TAMPER: mode_r <= MODE_TAMPER;
                default:
                begin
                    if (cfg_ok && tamper_en && i_tamper_sense)
                        mode_r <= MODE_TAMPER; // [RL8] [RL14]
                    else if (cfg_ok && keytest_req)
                        mode_r <= MODE_KEYTEST; // [RL9]
                    else if (cfg_ok && disptest_req)
                        mode_r <= MODE_DISPTEST; // [RL10]
                    else
                        mode_r <= MODE_RUN;
                end
            endcase
        end
    end

    // --------------------------------------------------------------
    // flash divider (toggles flash_r) and display step divider (advances digit_r)
    // --------------------------------------------------------------
    logic [31:0] flash_cnt_r;
    logic flash_r;
    logic [31:0] step_cnt_r;
    logic [3:0] digit_r;
    always_ff @(posedge i_clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            flash_cnt_r <= '0;
            flash_r <= 1'b0;
        end
        else if (flash_cnt_r >= FLASH_HALF_CYC - 1)
        begin
            flash_cnt_r <= '0;
            flash_r <= ~flash_r;
        end
        else
            flash_cnt_r <= flash_cnt_r + 32'h1;
    end

    always_ff @(posedge i_clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            step_cnt_r <= '0;
            digit_r <= '0;
        end
        else if (mode_r != MODE_DISPTEST)
        begin
            step_cnt_r <= '0;
            digit_r <= '0;
        end
        else if (step_cnt_r >= STEP_LEN_CYC - 1)
        begin
            step_cnt_r <= '0;
            digit_r <= (digit_r == 4'(DIGITS - 1)) ? 4'h0 : digit_r + 4'h1; // [RL10]
        end
        else
            step_cnt_r <= step_cnt_r + 32'h1;
    end

    // --------------------------------------------------------------
    // inter-key timeout (older variant switch selects length)
    // --------------------------------------------------------------
    logic [31:0] to_cnt_r;
    logic [31:0] to_limit;
    assign to_limit = (!i_newer_variant && sw[SW_TIMEOUT_DUAL]) ? TO_LONG_CYC
                                                                 : TO_SHORT_CYC; // [RL6]
    always_ff @(posedge i_clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            to_cnt_r <= '0;
            o_entry_abort <= 1'b0;
        end
        else
        begin
            o_entry_abort <= 1'b0;
            if (!i_entry_active || i_key_strobe || mode_r != MODE_RUN)
                to_cnt_r <= '0;
            else if (to_cnt_r >= to_limit - 1)
            begin
                to_cnt_r <= '0;
                o_entry_abort <= 1'b1; // [RL7]
            end
            else
                to_cnt_r <= to_cnt_r + 32'h1;
        end
    end

    // --------------------------------------------------------------
    // indicators
    // --------------------------------------------------------------
    logic dup_r;
    always_ff @(posedge i_clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dup_r <= 1'b0;
            o_red_front <= 1'b0;
            o_all_red <= 1'b0;
            o_tamper_alarm <= 1'b0;
            o_device_disabled <= 1'b0;
            o_bottom_leds <= '0;
            o_digit_sel <= '0;
            o_segments <= '0;
        end
        else
        begin
            dup_r <= i_dup_addr_seen;
            o_red_front <= dup_r & flash_r; // [RL5]
            o_all_red <= (mode_r == MODE_TAMPER) & flash_r; // [RL8]
            o_tamper_alarm <= (mode_r == MODE_TAMPER); // [RL8]
            o_device_disabled <= (mode_r == MODE_TAMPER);
            if (mode_r == MODE_KEYTEST && i_key_strobe)
                o_bottom_leds <= i_key_code; // [RL9]
            else if (mode_r != MODE_KEYTEST)
                o_bottom_leds <= '0;
            if (mode_r == MODE_DISPTEST)
            begin
                o_digit_sel <= DIGITS'(1) << digit_r; // [RL10]
                o_segments <= SEG_EIGHT;
            end
            else
            begin
                o_digit_sel <= '0;
                o_segments <= '0;
            end
        end
    end

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    sequence tamper_hit_s;
        cfg_ok && tamper_en && i_tamper_sense && mode_r != MODE_TAMPER;
    endsequence
    addr_decode_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n) // [RL1]
        1'b1 |=> o_unit_address == (($past(sw[3:0]) == 4'h0) ? ADDR_ALL_OFF
            : {1'b0, $past(sw[0]), $past(sw[1]), $past(sw[2]), $past(sw[3])}))
        else $error("unit address mismatch");
    tamper_lock_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n) // [RL8]
        tamper_hit_s |=> ##1 o_device_disabled && o_tamper_alarm)
        else $error("tamper did not disable");
    tamper_hold_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n) // [RL14]
        o_device_disabled |=> o_device_disabled)
        else $error("disable released");
    key_show_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n) // [RL9]
        mode_r == MODE_KEYTEST && i_key_strobe |=> o_bottom_leds == $past(i_key_code))
        else $error("key test code wrong");
    disp_eight_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n) // [RL10]
        mode_r == MODE_DISPTEST |=> o_segments == SEG_EIGHT && $onehot(o_digit_sel))
        else $error("display test pattern wrong");
    abort_cause_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n) // [RL7]
        o_entry_abort |-> $past(i_entry_active) && !$past(i_key_strobe))
        else $error("abort without idle entry");
    reader_cfg_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n) // [RL11]
        !i_newer_variant ##1 !i_newer_variant |-> !o_reader2_enable && !o_fmt_wiegand)
        else $error("reader setting on older variant");
    test_gate_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n) // [RL15]
        i_newer_variant && !sw[SW_TEST_EN] && mode_r != MODE_TAMPER |=>
            mode_r == MODE_RUN || mode_r == MODE_TAMPER)
        else $error("test ran without enable");
    dup_flash_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n) // [RL5]
        o_red_front |-> $past(dup_r))
        else $error("red flash without duplicate");
endmodule : keypad_config
`default_nettype wire

// [bench/access_panel_model.sv]
// behavioural access-control panel polling one keypad
// assumes the keypad's decoded address and tamper alarm on the same clock
`timescale 1ns/1ns
`default_nettype none
module access_panel_model
(
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_cfg_valid,
    input wire logic [4:0] i_unit_address,
    input wire logic i_tamper_alarm,
    output logic [3:0] o_door,
    output logic o_exit,
    output logic o_known,
    output logic o_alarm
);
    // --------------------------------
    // address poll and door mapping
    // --------------------------------
    // the tamper alarm is only acted on once the address has been read
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_known <= 1'b0;
            o_door <= 4'h0;
            o_exit <= 1'b0;
            o_alarm <= 1'b0;
        end
        else
        begin
            o_known <= i_cfg_valid && (i_unit_address >= 5'h01) && (i_unit_address <= 5'h10);
            o_exit <= i_unit_address > 5'h08;
            o_door <= (i_unit_address > 5'h08) ? 4'(i_unit_address - 5'h08) : i_unit_address[3:0];
            o_alarm <= o_known && i_tamper_alarm;
        end
    end
endmodule : access_panel_model
`default_nettype wire

// [bench/tb_keypad_config.sv]
// self-checking bench for the keypad configuration logic
// assumes shortened counts set through the design's parameters
`timescale 1ns/1ns
`default_nettype none
module tb_keypad_config
    import keypad_cfg_pkg::*;
;
    localparam int TL = 150;
    localparam int TS = 100;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic nv = 1'b0;
    logic [9:0] sw = 10'h000;
    logic ks = 1'b0;
    logic [3:0] kc = 4'h0;
    logic ea = 1'b0;
    logic dup = 1'b0;
    logic ts = 1'b0;
    wire logic [4:0] addr;
    wire logic [3:0] leds, door, dsel;
    wire logic [6:0] seg;
    wire logic cv, ab, r2, fw, si, ta, dis, rf, ar, pexit, pknown, palarm;
    int bad_count = 0;
    int cmp_count = 0;
    logic v;
    logic [3:0] kc_tab [4] = '{KEY_HASH, KEY_STAR, KEY_START, 4'h7};

    always #50 clk = ~clk;

    keypad_config #(.TO_LONG_CYC(TL), .TO_SHORT_CYC(TS), .DEB_CYC(4), .FLASH_HALF_CYC(4),
        .STEP_LEN_CYC(8), .DIGITS(4)) DUT (.i_clk_sys(clk), .i_reset_n(rst_n),
        .i_newer_variant(nv), .i_addr_weight8_switch(sw[0]), .i_addr_weight4_switch(sw[1]),
        .i_addr_weight2_switch(sw[2]), .i_addr_weight1_switch(sw[3]),
        .i_timeout_or_dual_reader_switch(sw[4]), .i_tamper_or_format_switch(sw[5]),
        .i_keytest_or_style_switch(sw[6]), .i_display_test_or_tamper_switch(sw[7]),
        .i_test_select_switch(sw[8]), .i_test_enable_switch(sw[9]), .i_key_strobe(ks),
        .i_key_code(kc), .i_entry_active(ea), .i_dup_addr_seen(dup), .i_tamper_sense(ts),
        .o_unit_address(addr), .o_cfg_valid(cv), .o_entry_abort(ab), .o_reader2_enable(r2),
        .o_fmt_wiegand(fw), .o_style_insert(si), .o_tamper_alarm(ta), .o_device_disabled(dis),
        .o_red_front(rf), .o_all_red(ar), .o_bottom_leds(leds), .o_digit_sel(dsel),
        .o_segments(seg));

    access_panel_model panel (.i_clk_sys(clk), .i_rst_n(rst_n), .i_cfg_valid(cv),
        .i_unit_address(addr), .i_tamper_alarm(ta), .o_door(door), .o_exit(pexit),
        .o_known(pknown), .o_alarm(palarm));

    // --------------------------------
    // shared tasks
    // --------------------------------
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e)
        begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            bad_count++;
        end
    endtask : chk

    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask : wt

    // switches change, then wait out debounce and output latency
    task automatic set_sw(input logic [9:0] s);
        @(negedge clk);
        sw = s;
        wt(12);
    endtask : set_sw

    task automatic press(input logic [3:0] c);
        @(negedge clk);
        ks = 1'b1;
        kc = c;
        @(negedge clk);
        ks = 1'b0;
    endtask : press

    // entry timer: cycles from activation to abort, optional key part way
    task automatic tmo(input int lim, input int kat);
        int n;
        n = 0;
        @(negedge clk);
        ea = 1'b1;
        while (ab !== 1'b1 && n < 400)
        begin
            @(negedge clk);
            n++;
            ks = (n == kat);
        end
        chk("abort_time", 8'h01, 8'((n >= lim + kat) && (n <= lim + kat + 3)));
        ea = 1'b0;
    endtask : tmo

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_sim

    // --------------------------------
    // watchdog
    // --------------------------------
    initial
    begin
        #(100 * 20000);
        bad_count++;
        end_sim();
    end

    // --------------------------------
    // test sequence
    // --------------------------------
    initial
    begin
        wt(8);
        chk("addr_in_reset", 8'h10, 8'(addr));
        chk("valid_in_reset", 8'h00, 8'(cv));
        rst_n = 1'b1;
        wt(12);
        chk("addr_all_off", 8'h10, 8'(addr));
        chk("panel_exit8", 8'h18, {3'h0, pexit, door});
        chk("panel_known", 8'h01, 8'(pknown));
        chk("valid_after", 8'h01, 8'(cv));
        // address table: weight 8 is sw[0]
        for (int a = 1; a < 16; a++)
        begin
            set_sw({6'h00, a[0], a[1], a[2], a[3]});
            chk("unit_addr", 8'(a), 8'(addr));
            chk("panel_door", 8'((a > 8) ? a - 8 + 16 : a), {3'h0, pexit, door});
        end
        // short glitch on a switch is ignored
        @(negedge clk);
        sw[0] = 1'b0;
        wt(2);
        sw[0] = 1'b1;
        wt(10);
        chk("glitch_addr", 8'h0f, 8'(addr));
        // older variant: reader outputs stay low, timeouts 15 us / 10 us
        set_sw(10'h070);
        chk("older_readers", 8'h00, {5'h0, r2, fw, si});
        set_sw(10'h010);
        tmo(TL, 0);
        set_sw(10'h000);
        tmo(TS, 0);
        tmo(TS, 50);
        // newer variant reader settings
        nv = 1'b1;
        set_sw(10'h070);
        chk("newer_readers", 8'h07, {5'h0, r2, fw, si});
        set_sw(10'h020);
        chk("fmt_only", 8'h02, {5'h0, r2, fw, si});
        tmo(TS, 0);
        // newer tests: display, key, disabled
        set_sw(10'h200);
        chk("disp_seg", 8'h7f, 8'(seg));
        chk("disp_onehot", 8'h01, 8'($onehot(dsel)));
        wt(8);
        chk("disp_step", 8'h02, 8'(dsel));
        set_sw(10'h300);
        press(4'h3);
        chk("key_newer", 8'h03, 8'(leds));
        set_sw(10'h100);
        press(4'h5);
        chk("tests_off", 8'h00, 8'(leds));
        chk("seg_off", 8'h00, 8'(seg));
        // older key test codes
        nv = 1'b0;
        set_sw(10'h040);
        foreach (kc_tab[i])
        begin
            press(kc_tab[i]);
            chk("key_code", 8'(kc_tab[i]), 8'(leds));
        end
        // duplicate address flashing
        set_sw(10'h000);
        dup = 1'b1;
        wt(3);
        v = rf;
        wt(4);
        chk("red_flash", 8'h01, 8'(rf === ~v));
        dup = 1'b0;
        // tamper with detection off, then on
        ts = 1'b1;
        wt(5);
        chk("tamper_off", 8'h00, {6'h0, ta, dis});
        chk("red_off", 8'h00, 8'(rf));
        set_sw(10'h020);
        chk("tamper_on", 8'h03, {6'h0, ta, dis});
        chk("panel_alarm", 8'h01, 8'(palarm));
        v = ar;
        wt(4);
        chk("all_red_flash", 8'h01, 8'(ar === ~v));
        ts = 1'b0;
        set_sw(10'h000);
        chk("tamper_latched", 8'h03, {6'h0, ta, dis});
        nv = 1'b1;
        rst_n = 1'b0;
        wt(2);
        rst_n = 1'b1;
        ts = 1'b1;
        set_sw(10'h080);
        chk("tamper_newer", 8'h03, {6'h0, ta, dis});
        end_sim();
    end
endmodule : tb_keypad_config
`default_nettype wire
